// *** dv/pcc_capture_compare_tb.sv ***
module pcc_capture_compare_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] FLG = pcc_pkg::ADDR_FLAGS;
   localparam logic [7:0] CFG = pcc_pkg::ADDR_PWMCFG;
   localparam logic [7:0] PINS = pcc_pkg::ADDR_PINS;
   localparam logic [7:0] MODE = pcc_pkg::ADDR_MODE0;
   localparam logic [7:0] CPL = pcc_pkg::ADDR_CPL0;
   localparam logic [7:0] CPH = pcc_pkg::ADDR_CPH0;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   pcc_pkg::pcc_sfr_req_t sfr_req = '0;
   pcc_pkg::pcc_cnt_t cnt = '0;
   logic [7:0] sfr_rdata;
   logic [pcc_pkg::NCH-1:0] pin_in;
   logic [pcc_pkg::NCH-1:0] pin_out;
   logic [pcc_pkg::NCH-1:0] pin_oe_n;
   logic [pcc_pkg::NCH-1:0] src_level = '0;
   logic irq;
   int error_cnt = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   pcc_capture_compare dut
   (
      .clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cnt(cnt),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq)
   );

   pcc_pin_model pins_far
   (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_level(src_level), .pin_in(pin_in)
   );

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_req.wr <= 1'b1;
      sfr_req.addr <= a;
      sfr_req.wdata <= d;
      @(posedge clk);
      sfr_req.wr <= 1'b0;
      #1;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      sfr_req.rd <= 1'b1;
      sfr_req.addr <= a;
      @(posedge clk);
      sfr_req.rd <= 1'b0;
      #1;
      chk({8'h00, sfr_rdata & m}, {8'h00, e});
   endtask

   // Counter advances for one cycle; returns once the registered outputs have moved
   task automatic tick(input logic [15:0] v);
      @(posedge clk);
      cnt <= '{value: v, tick: 1'b1};
      @(posedge clk);
      cnt.tick <= 1'b0;
      #1;
   endtask

   // Six clocks covers the two sampler stages with margin
   task automatic pin_edge(input logic lvl, input logic [15:0] v);
      @(posedge clk);
      cnt.value <= v;
      src_level[0] <= lvl;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      chk({13'h0000, pin_oe_n}, 16'h0007);
      rchk(MODE, 8'h00, 8'hFF);
      wr(8'h03, 8'hFF);
      rchk(8'h03, 8'h00, 8'hFF);
   endtask

   task automatic t_capture();
      wr(MODE, 8'h21);
      pin_edge(1'b1, 16'h1234);
      chk({15'h0000, irq}, 16'h0001);
      rchk(CPL, 8'h34, 8'hFF);
      rchk(CPH, 8'h12, 8'hFF);
      rchk(FLG, 8'h01, 8'h07);
      pin_edge(1'b0, 16'h5678);
      rchk(CPH, 8'h12, 8'hFF);
      wr(MODE, 8'h10);
      pin_edge(1'b1, 16'h9999);
      rchk(CPH, 8'h12, 8'hFF);
      pin_edge(1'b0, 16'h9ABC);
      rchk(CPH, 8'h9A, 8'hFF);
      wr(MODE, 8'h30);
      chk({15'h0000, irq}, 16'h0000);
      pin_edge(1'b1, 16'h5678);
      rchk(CPH, 8'h56, 8'hFF);
      rchk(PINS, 8'h01, 8'h01);
      rchk(FLG, 8'h01, 8'h01);
      wr(FLG, 8'h00);
      rchk(FLG, 8'h00, 8'h07);
   endtask

   task automatic t_timer();
      wr(MODE + 8'h01, 8'h48);
      wr(CPL + 8'h01, 8'h10);
      rchk(MODE + 8'h01, 8'h08, 8'hFF);
      wr(CPH + 8'h01, 8'h00);
      rchk(MODE + 8'h01, 8'h48, 8'hFF);
      @(posedge clk);
      cnt.value <= 16'h0010;
      repeat (3) @(posedge clk);
      rchk(FLG, 8'h00, 8'h02);
      tick(16'h000F);
      rchk(FLG, 8'h00, 8'h02);
      tick(16'h0010);
      rchk(FLG, 8'h02, 8'h02);
      chk({15'h0000, irq}, 16'h0000);
   endtask

   task automatic t_hso();
      wr(MODE + 8'h02, 8'h4C);
      wr(CPL + 8'h02, 8'h20);
      wr(CPH + 8'h02, 8'h00);
      tick(16'h0020);
      chk({15'h0000, pin_out[2]}, 16'h0001);
      chk({13'h0000, pin_oe_n}, 16'h0003);
      rchk(FLG, 8'h04, 8'h04);
      tick(16'h0021);
      chk({15'h0000, pin_out[2]}, 16'h0001);
      tick(16'h0020);
      chk({15'h0000, pin_out[2]}, 16'h0000);
      wr(CPL + 8'h02, 8'h20);
      tick(16'h0020);
      chk({15'h0000, pin_out[2]}, 16'h0000);
   endtask

   task automatic t_freq();
      wr(FLG, 8'h00);
      wr(MODE, 8'h46);
      wr(CPL, 8'h05);
      wr(CPH, 8'h03);
      tick(16'h0005);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      rchk(CPL, 8'h08, 8'hFF);
      tick(16'h0305);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      tick(16'h0308);
      chk({15'h0000, pin_out[0]}, 16'h0000);
      rchk(FLG, 8'h00, 8'h01);
      wr(CPH, 8'h00);
      tick(16'h000B);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      rchk(CPL, 8'h0B, 8'hFF);
      wr(MODE, 8'h4E);
      tick(16'h110B);
      rchk(FLG, 8'h00, 8'h01);
      tick(16'h000B);
      rchk(FLG, 8'h01, 8'h01);
   endtask

   task automatic t_pwm8();
      wr(CFG, 8'h00);
      wr(MODE + 8'h01, 8'h4A);
      wr(CPL + 8'h01, 8'h80);
      wr(CPH + 8'h01, 8'h40);
      wr(FLG, 8'h00);
      tick(16'h0080);
      chk({15'h0000, pin_out[1]}, 16'h0001);
      rchk(FLG, 8'h02, 8'h02);
      tick(16'h00FF);
      chk({15'h0000, pin_out[1]}, 16'h0000);
      rchk(CPL + 8'h01, 8'h40, 8'hFF);
      tick(16'h0040);
      chk({15'h0000, pin_out[1]}, 16'h0001);
   endtask

   task automatic t_pwm9();
      wr(MODE + 8'h02, 8'h02);
      wr(CFG, 8'hA1);
      wr(CPL + 8'h02, 8'h50);
      wr(CPH + 8'h02, 8'h01);
      wr(CFG, 8'h21);
      wr(CPL + 8'h02, 8'h00);
      wr(CPH + 8'h02, 8'h01);
      rchk(CPL + 8'h02, 8'h00, 8'hFF);
      tick(16'h0100);
      chk({15'h0000, pin_out[2]}, 16'h0001);
      tick(16'h01FF);
      chk({15'h0000, pin_out[2]}, 16'h0000);
      chk({15'h0000, irq}, 16'h0001);
      rchk(CFG, 8'h61, 8'hFF);
      rchk(CPL + 8'h02, 8'h50, 8'hFF);
      rchk(CPH + 8'h02, 8'h01, 8'hFF);
      // Module 1 shares the 9-bit length and reloads its zero reload value
      rchk(CPL + 8'h01, 8'h00, 8'hFF);
      wr(CFG, 8'h01);
      chk({15'h0000, irq}, 16'h0000);
   endtask

   // Overflow point moves with the shared length field, whatever the modules do
   task automatic t_length();
      for (int i = 0; i < 4; i++)
      begin
         wr(CFG, 8'(i));
         tick((16'h0080 << i) - 16'h0001);
         rchk(CFG, 8'(i), 8'hFF);
         tick((16'h0100 << i) - 16'h0001);
         rchk(CFG, 8'h40 | 8'(i), 8'hFF);
      end
   endtask

   // Module 0 passes through timer, idle high-speed output and 8-bit PWM so its checks fire
   task automatic t_mod0();
      wr(CFG, 8'h00);
      wr(MODE, 8'h48);
      wr(FLG, 8'h00);
      wr(CPL, 8'h30);
      wr(CPH, 8'h00);
      tick(16'h0030);
      rchk(FLG, 8'h01, 8'h01);
      wr(MODE, 8'h0C);
      tick(16'h0030);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      wr(MODE, 8'h4A);
      wr(CPL, 8'h20);
      wr(CPH, 8'h60);
      tick(16'h0020);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      tick(16'h00FF);
      chk({15'h0000, pin_out[0]}, 16'h0000);
      rchk(CPL, 8'h60, 8'hFF);
   endtask

   task automatic t_pwm16();
      wr(MODE, 8'hC2);
      wr(CPL, 8'h00);
      wr(CPH, 8'h10);
      tick(16'h1000);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      tick(16'h17FF);
      chk({15'h0000, pin_out[0]}, 16'h0001);
      tick(16'hFFFF);
      chk({15'h0000, pin_out[0]}, 16'h0000);
      wr(CPL, 8'h00);
      tick(16'h1000);
      chk({15'h0000, pin_out[0]}, 16'h0000);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_capture();
      t_timer();
      t_hso();
      t_freq();
      t_pwm8();
      t_pwm9();
      t_length();
      t_mod0();
      t_pwm16();
      tally_and_finish();
   end
endmodule

// *** dv/pcc_pin_model.sv ***
module pcc_pin_model
(
   // Design side of each module pin
   input wire logic [pcc_pkg::NCH-1:0] pin_out,
   input wire logic [pcc_pkg::NCH-1:0] pin_oe_n,
   // Level the outside source wants on each pin
   input wire logic [pcc_pkg::NCH-1:0] src_level,
   // Resolved wire level
   output logic [pcc_pkg::NCH-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Source steps back while the module drives, so the wire never fights
   // Source levels only change through the bench, which holds them for six clocks
   always_comb
      for (int i = 0; i < pcc_pkg::NCH; i++)
         pin_in[i] = pin_oe_n[i] ? src_level[i] : pin_out[i];
endmodule

// *** include/pcc_pkg.sv ***
package pcc_pkg;

   // Channel count and register port width
   localparam int NCH = 3;
   localparam int AW = 8;

   // Register addresses on the special-function register port
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_PWMCFG = 8'h01;
   localparam logic [7:0] ADDR_PINS = 8'h02;
   localparam logic [7:0] ADDR_MODE0 = 8'h04;
   localparam logic [7:0] ADDR_CPL0 = 8'h08;
   localparam logic [7:0] ADDR_CPH0 = 8'h0C;

   // Mode register bit positions
   localparam int MB_IRQEN = 0;
   localparam int MB_PWM = 1;
   localparam int MB_TOG = 2;
   localparam int MB_MAT = 3;
   localparam int MB_FALL = 4;
   localparam int MB_RISE = 5;
   localparam int MB_ECOM = 6;
   localparam int MB_WIDE = 7;

   // Cycle configuration bit positions
   localparam int PB_CLS_LO = 0;
   localparam int PB_CLS_HI = 1;
   localparam int PB_OVIE = 5;
   localparam int PB_OVF = 6;
   localparam int PB_RELOAD_WINDOW_SELECT = 7;

   // Reset values and counter constants
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [1:0] CLS_8BIT = 2'b00;
   localparam logic [1:0] CLS_9BIT = 2'b01;
   localparam logic [1:0] CLS_10BIT = 2'b10;
   localparam logic [15:0] MASK_8 = 16'h00FF;
   localparam logic [15:0] MASK_9 = 16'h01FF;
   localparam logic [15:0] MASK_10 = 16'h03FF;
   localparam logic [15:0] MASK_11 = 16'h07FF;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [5:0] {
      MD_CAPTURE = 6'b00_0001,
      MD_TIMER = 6'b00_0010,
      MD_HSO = 6'b00_0100,
      MD_FREQ = 6'b00_1000,
      MD_PWM_LOW = 6'b01_0000,
      MD_PWM16 = 6'b10_0000
   } pcc_mode_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] cmp;
      logic [15:0] reload;
      logic pin;
   } pcc_chan_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcc_sfr_req_t;

   typedef struct packed {
      logic [15:0] value;
      logic tick;
   } pcc_cnt_t;

   typedef struct packed {
      logic [NCH-1:0] now;
      logic [NCH-1:0] prev;
   } pcc_edge_st_t;

   function automatic pcc_mode_t decode_mode(input logic [7:0] m);
      if (m[MB_PWM] && m[MB_TOG])
         return MD_FREQ;
      else if (m[MB_PWM] && m[MB_WIDE])
         return MD_PWM16;
      else if (m[MB_PWM])
         return MD_PWM_LOW;
      else if (m[MB_TOG])
         return MD_HSO;
      else if (m[MB_MAT])
         return MD_TIMER;
      else
         return MD_CAPTURE;
   endfunction

   function automatic logic [15:0] len_mask(input logic [1:0] cls);
      unique case (cls)
         CLS_8BIT: return MASK_8;
         CLS_9BIT: return MASK_9;
         CLS_10BIT: return MASK_10;
         default: return MASK_11;
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
      return a == (base + 8'(idx));
   endfunction

endpackage

// *** verilog/pcc_capture_compare.sv ***
// How it works
// [RQ1] Each module keeps its own mode byte and runs in its mode alone.
// [RQ2] One shared cycle-length field serves every module in 8 to 11-bit PWM.
// [RQ3] Cycle-length field 00/01/10/11 selects 8/9/10/11-bit PWM.
// [RQ4] Interrupt enable bit 0 lets a set module flag raise the interrupt.
// [RQ5] Capture mode: bits 3-1 zero; bit 5 rising, bit 4 falling, both either.
// [RQ6] Selected pin edge copies the counter into the module value and sets flag.
// [RQ7] Outside source holds each capture level at least two clocks.
// [RQ8] The sampled pin level stays readable to tell which edge captured.
// [RQ9] Module flags stay set until software writes them clear.
// [RQ10] Software timer: comparator and match enables; flag on 16-bit equality.
// [RQ11] Low byte write clears comparator enable; high byte write sets it.
// [RQ12] Software writes low byte before high byte.
// [RQ13] High-speed output: toggle pin on each 16-bit match; set flag when match enable is set.
// [RQ14] Comparator off in high-speed output holds the pin and stops toggling.
// [RQ15] Frequency output: low byte match toggles pin, adds high byte to low.
// [RQ16] Frequency high byte counts half-period clocks; zero acts as 256.
// [RQ17] Frequency output selected by toggle and PWM bits both set.
// [RQ18] Frequency mode with match enable flags only on full 16-bit equality.
// [RQ19] Comparator off: no toggling, and every PWM mode drives low.
// [RQ20] PWM modes set the module flag on match when match enable is set.
// [RQ21] Config bit 5 enables interrupt on overflow from the selected bit.
// [RQ22] Config bit 7 steers data bytes: 0 module value, 1 reload value.
// [RQ23] Mode bit 7 with PWM bit set and toggle bit clear picks 16-bit PWM, ignoring cycle length.
// [RQ24] 8-bit PWM: high on low byte match, low on overflow, low reloads high.
// [RQ25] 9-11 bit PWM: high on N-bit match; overflow lowers, flags, reloads.
// [RQ26] 16-bit PWM: high on 16-bit match, low on 16-bit overflow.
// [RQ27] Compare, toggle and PWM events only on counter ticks, current value.
module pcc_capture_compare
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire pcc_pkg::pcc_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Shared counter
   input wire pcc_pkg::pcc_cnt_t cnt,
   // Module pins
   input wire logic [pcc_pkg::NCH-1:0] pin_in,
   output logic [pcc_pkg::NCH-1:0] pin_out,
   output logic [pcc_pkg::NCH-1:0] pin_oe_n,
   // Interrupt request
   output logic irq
);

   typedef struct packed {
      pcc_pkg::pcc_chan_t [pcc_pkg::NCH-1:0] ch;
      logic [pcc_pkg::NCH-1:0] flags;
      logic [1:0] cls;
      logic ovie;
      logic ovf;
      logic reload_window_select;
      logic [pcc_pkg::NCH-1:0] oe_n;
      logic [7:0] rdata;
      logic irq;
   } pcc_state_t;

   pcc_state_t st_r;
   pcc_state_t st_nxt;
   logic [pcc_pkg::NCH-1:0] pin_lvl;
   logic [pcc_pkg::NCH-1:0] pin_rise;
   logic [pcc_pkg::NCH-1:0] pin_fall;

   pcc_edge_sampler u_edge
   (
      .clk(clk),
      .rstn(rstn),
      .pin_in(pin_in),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   always_comb
   begin
      pcc_pkg::pcc_mode_t md;
      logic [15:0] msk;
      logic [pcc_pkg::NCH-1:0] set_vec;
      logic [pcc_pkg::NCH-1:0] ien;
      logic m16;
      logic ecom;
      logic mat;
      logic ovf_n;
      md = pcc_pkg::MD_CAPTURE;
      msk = pcc_pkg::len_mask(st_r.cls); // [RQ2] [RQ3]
      set_vec = '0;
      ien = '0;
      m16 = 1'b0;
      ecom = 1'b0;
      mat = 1'b0;
      // Overflow out of bit N, seen on the tick that wraps the low N bits
      ovf_n = cnt.tick && ((cnt.value & msk) == msk); // [RQ27]
      st_nxt = st_r;

      for (int i = 0; i < pcc_pkg::NCH; i++)
      begin
         md = pcc_pkg::decode_mode(st_r.ch[i].mode); // [RQ1] [RQ17] [RQ23]
         ecom = st_r.ch[i].mode[pcc_pkg::MB_ECOM];
         mat = st_r.ch[i].mode[pcc_pkg::MB_MAT];
         m16 = cnt.tick && (cnt.value == st_r.ch[i].cmp); // [RQ27]
         unique case (md)
            pcc_pkg::MD_CAPTURE:
            begin
               // Capture is not tied to the tick: pin edges are sampled every clock
               if ((pin_rise[i] && st_r.ch[i].mode[pcc_pkg::MB_RISE]) ||
                   (pin_fall[i] && st_r.ch[i].mode[pcc_pkg::MB_FALL])) // [RQ5]
               begin
                  st_nxt.ch[i].cmp = cnt.value; // [RQ6]
                  set_vec[i] = 1'b1;
               end
            end
            pcc_pkg::MD_TIMER:
            begin
               if (ecom && m16)
                  set_vec[i] = 1'b1; // [RQ10]
            end
            pcc_pkg::MD_HSO:
            begin
               // Comparator off leaves the pin where it is
               if (ecom && m16) // [RQ14] [RQ19]
               begin
                  st_nxt.ch[i].pin = ~st_r.ch[i].pin; // [RQ13]
                  set_vec[i] = mat;
               end
            end
            pcc_pkg::MD_FREQ:
            begin
               if (ecom && cnt.tick && (cnt.value[7:0] == st_r.ch[i].cmp[7:0])) // [RQ19]
               begin
                  st_nxt.ch[i].pin = ~st_r.ch[i].pin; // [RQ15]
                  // Adding zero lands on the same value again, 256 counts later
                  st_nxt.ch[i].cmp[7:0] = st_r.ch[i].cmp[7:0] + st_r.ch[i].cmp[15:8]; // [RQ16]
               end
               if (mat && m16)
                  set_vec[i] = 1'b1; // [RQ18]
            end
            pcc_pkg::MD_PWM_LOW:
            begin
               if (ovf_n)
               begin
                  st_nxt.ch[i].pin = 1'b0;
                  if (st_r.cls == pcc_pkg::CLS_8BIT)
                     st_nxt.ch[i].cmp[7:0] = st_r.ch[i].cmp[15:8]; // [RQ24]
                  else
                     st_nxt.ch[i].cmp = st_r.ch[i].reload; // [RQ25]
               end
               // Match after overflow so the all-ones value keeps the pin high across the overflow
               if (cnt.tick && ((cnt.value & msk) == (st_r.ch[i].cmp & msk))) // [RQ24] [RQ25]
               begin
                  st_nxt.ch[i].pin = 1'b1;
                  set_vec[i] = mat; // [RQ20]
               end
               if (!ecom)
                  st_nxt.ch[i].pin = 1'b0; // [RQ19]
            end
            pcc_pkg::MD_PWM16:
            begin
               if (cnt.tick && (cnt.value == pcc_pkg::CNT_MAX))
                  st_nxt.ch[i].pin = 1'b0; // [RQ26]
               if (m16)
               begin
                  st_nxt.ch[i].pin = 1'b1; // [RQ26]
                  set_vec[i] = mat; // [RQ20]
               end
               if (!ecom)
                  st_nxt.ch[i].pin = 1'b0; // [RQ19]
            end
         endcase
         st_nxt.oe_n[i] = (md == pcc_pkg::MD_CAPTURE) || (md == pcc_pkg::MD_TIMER);

         // Register writes win over same-cycle hardware updates of the data bytes
         if (sfr_req.wr && pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_MODE0, i))
            st_nxt.ch[i].mode = sfr_req.wdata;
         if (sfr_req.wr && pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_CPL0, i))
         begin
            if (st_r.reload_window_select)
               st_nxt.ch[i].reload[7:0] = sfr_req.wdata; // [RQ22]
            else
               st_nxt.ch[i].cmp[7:0] = sfr_req.wdata;
            st_nxt.ch[i].mode[pcc_pkg::MB_ECOM] = 1'b0; // [RQ11]
         end
         if (sfr_req.wr && pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_CPH0, i))
         begin
            if (st_r.reload_window_select)
               st_nxt.ch[i].reload[15:8] = sfr_req.wdata; // [RQ22]
            else
               st_nxt.ch[i].cmp[15:8] = sfr_req.wdata;
            st_nxt.ch[i].mode[pcc_pkg::MB_ECOM] = 1'b1; // [RQ11]
         end
      end

      // Flags: software write first, hardware set on top so no event is lost
      if (sfr_req.wr && (sfr_req.addr == pcc_pkg::ADDR_FLAGS))
         st_nxt.flags = sfr_req.wdata[pcc_pkg::NCH-1:0];
      st_nxt.flags = st_nxt.flags | set_vec; // [RQ9]

      if (sfr_req.wr && (sfr_req.addr == pcc_pkg::ADDR_PWMCFG))
      begin
         st_nxt.cls = sfr_req.wdata[pcc_pkg::PB_CLS_HI:pcc_pkg::PB_CLS_LO]; // [RQ3]
         st_nxt.ovie = sfr_req.wdata[pcc_pkg::PB_OVIE];
         st_nxt.ovf = sfr_req.wdata[pcc_pkg::PB_OVF];
         st_nxt.reload_window_select = sfr_req.wdata[pcc_pkg::PB_RELOAD_WINDOW_SELECT];
      end
      if (ovf_n)
         st_nxt.ovf = 1'b1; // [RQ25]

      for (int i = 0; i < pcc_pkg::NCH; i++)
         ien[i] = st_nxt.ch[i].mode[pcc_pkg::MB_IRQEN];
      st_nxt.irq = (|(st_nxt.flags & ien)) || (st_nxt.ovf && st_nxt.ovie); // [RQ4] [RQ21]

      // Read data is captured on the read strobe and held until the next read
      if (sfr_req.rd)
      begin
         st_nxt.rdata = pcc_pkg::BYTE_ZERO;
         if (sfr_req.addr == pcc_pkg::ADDR_FLAGS)
            st_nxt.rdata[pcc_pkg::NCH-1:0] = st_r.flags;
         if (sfr_req.addr == pcc_pkg::ADDR_PWMCFG)
         begin
            st_nxt.rdata[pcc_pkg::PB_CLS_HI:pcc_pkg::PB_CLS_LO] = st_r.cls;
            st_nxt.rdata[pcc_pkg::PB_OVIE] = st_r.ovie;
            st_nxt.rdata[pcc_pkg::PB_OVF] = st_r.ovf;
            st_nxt.rdata[pcc_pkg::PB_RELOAD_WINDOW_SELECT] = st_r.reload_window_select;
         end
         if (sfr_req.addr == pcc_pkg::ADDR_PINS)
            st_nxt.rdata[pcc_pkg::NCH-1:0] = pin_lvl; // [RQ8]
         for (int i = 0; i < pcc_pkg::NCH; i++)
         begin
            if (pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_MODE0, i))
               st_nxt.rdata = st_r.ch[i].mode;
            if (pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_CPL0, i))
               st_nxt.rdata = st_r.reload_window_select ? st_r.ch[i].reload[7:0] : st_r.ch[i].cmp[7:0]; // [RQ22]
            if (pcc_pkg::hit(sfr_req.addr, pcc_pkg::ADDR_CPH0, i))
               st_nxt.rdata = st_r.reload_window_select ? st_r.ch[i].reload[15:8] : st_r.ch[i].cmp[15:8]; // [RQ22]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
         st_r.oe_n <= '1;
         for (int i = 0; i < pcc_pkg::NCH; i++)
         begin
            st_r.ch[i].mode <= pcc_pkg::MODE_RST;
            st_r.ch[i].cmp <= pcc_pkg::CMP_RST;
            st_r.ch[i].reload <= pcc_pkg::CMP_RST;
         end
         st_r.cls <= pcc_pkg::CLS_8BIT;
      end
      else
         st_r <= st_nxt;
   end

   assign sfr_rdata = st_r.rdata;
   assign irq = st_r.irq;
   always_comb
   begin
      for (int i = 0; i < pcc_pkg::NCH; i++)
         pin_out[i] = st_r.ch[i].pin;
   end
   assign pin_oe_n = st_r.oe_n;

   // Checks on module 0; the modules share one code path
   logic wr_cpl0;
   logic wr_cph0;
   logic wr_flags;
   pcc_pkg::pcc_mode_t md0;
   assign wr_cpl0 = sfr_req.wr && (sfr_req.addr == pcc_pkg::ADDR_CPL0);
   assign wr_cph0 = sfr_req.wr && (sfr_req.addr == pcc_pkg::ADDR_CPH0);
   assign wr_flags = sfr_req.wr && (sfr_req.addr == pcc_pkg::ADDR_FLAGS);
   assign md0 = pcc_pkg::decode_mode(st_r.ch[0].mode);

   property p_low_write_clears_ecom;
      @(posedge clk) disable iff (!rstn)
      wr_cpl0 |=> !st_r.ch[0].mode[pcc_pkg::MB_ECOM];
   endproperty
   a_low_write_clears_ecom: assert property (p_low_write_clears_ecom) else $error("low write kept ecom"); // [RQ11]

   property p_high_write_sets_ecom;
      @(posedge clk) disable iff (!rstn)
      wr_cph0 |=> st_r.ch[0].mode[pcc_pkg::MB_ECOM] && (st_r.ch[0].cmp[15:8] == $past(sfr_req.wdata) || st_r.reload_window_select);
   endproperty
   a_high_write_sets_ecom: assert property (p_high_write_sets_ecom) else $error("high write missed"); // [RQ11]

   property p_capture_loads;
      @(posedge clk) disable iff (!rstn)
      (md0 == pcc_pkg::MD_CAPTURE && pin_rise[0] && st_r.ch[0].mode[pcc_pkg::MB_RISE] && !wr_cpl0 && !wr_cph0)
      |=> (st_r.ch[0].cmp == $past(cnt.value)) && st_r.flags[0];
   endproperty
   a_capture_loads: assert property (p_capture_loads) else $error("capture did not load"); // [RQ6]

   property p_timer_flag;
      @(posedge clk) disable iff (!rstn)
      (md0 == pcc_pkg::MD_TIMER && st_r.ch[0].mode[pcc_pkg::MB_ECOM] && cnt.tick && cnt.value == st_r.ch[0].cmp)
      |=> st_r.flags[0];
   endproperty
   a_timer_flag: assert property (p_timer_flag) else $error("timer match lost"); // [RQ10]

   property p_flag_sticky;
      @(posedge clk) disable iff (!rstn)
      (st_r.flags[0] && !wr_flags) |=> st_r.flags[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware"); // [RQ9]

   property p_pwm_off_low;
      @(posedge clk) disable iff (!rstn)
      ((md0 == pcc_pkg::MD_PWM_LOW || md0 == pcc_pkg::MD_PWM16) && !st_nxt.ch[0].mode[pcc_pkg::MB_ECOM]
       && st_nxt.ch[0].mode == st_r.ch[0].mode) ##1 !st_r.ch[0].mode[pcc_pkg::MB_ECOM] |-> !pin_out[0];
   endproperty
   a_pwm_off_low: assert property (p_pwm_off_low) else $error("pwm not low with comparator off"); // [RQ19]

   property p_hso_hold;
      @(posedge clk) disable iff (!rstn)
      (md0 == pcc_pkg::MD_HSO && !st_r.ch[0].mode[pcc_pkg::MB_ECOM]) |=> $stable(pin_out[0]);
   endproperty
   a_hso_hold: assert property (p_hso_hold) else $error("hso toggled while off"); // [RQ14]

   property p_pwm8_reload;
      @(posedge clk) disable iff (!rstn)
      (md0 == pcc_pkg::MD_PWM_LOW && st_r.cls == pcc_pkg::CLS_8BIT && cnt.tick && cnt.value[7:0] == 8'hFF
       && st_r.ch[0].cmp[7:0] != 8'hFF && !wr_cpl0 && !wr_cph0)
      |=> !pin_out[0] && (st_r.ch[0].cmp[7:0] == $past(st_r.ch[0].cmp[15:8])) && st_r.ovf;
   endproperty
   a_pwm8_reload: assert property (p_pwm8_reload) else $error("8-bit overflow wrong"); // [RQ24]

   property p_irq_follows;
      @(posedge clk) disable iff (!rstn)
      (st_r.flags[0] && st_r.ch[0].mode[pcc_pkg::MB_IRQEN]) |-> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised"); // [RQ4]

   property p_pwm16_rise;
      @(posedge clk) disable iff (!rstn)
      (md0 == pcc_pkg::MD_PWM16 && st_r.ch[0].mode[pcc_pkg::MB_ECOM] && cnt.tick && cnt.value == st_r.ch[0].cmp)
      |=> pin_out[0];
   endproperty
   a_pwm16_rise: assert property (p_pwm16_rise) else $error("pwm16 match did not raise pin"); // [RQ26]

endmodule

// *** verilog/pcc_edge_sampler.sv ***
module pcc_edge_sampler
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins
   input wire logic [pcc_pkg::NCH-1:0] pin_in,
   // Sampled level and edges
   output logic [pcc_pkg::NCH-1:0] level,
   output logic [pcc_pkg::NCH-1:0] rise,
   output logic [pcc_pkg::NCH-1:0] fall
);

   pcc_pkg::pcc_edge_st_t st_r;
   pcc_pkg::pcc_edge_st_t st_nxt;

   // Two sampled stages: a level sampled on a single clock is already seen as an edge
   always_comb
   begin
      st_nxt.now = pin_in;
      st_nxt.prev = st_r.now;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign level = st_r.now;
   assign rise = st_r.now & ~st_r.prev;
   assign fall = ~st_r.now & st_r.prev;

endmodule
